// file: logic/bor_exec.sv
// Execution unit for the byte-wide logical OR instruction family
// Notes on behaviour
// - Destination receives the bitwise OR of the two chosen bytes.
// - Status flags are never written by any byte OR form.
// - Six forms; four write the accumulator from register, direct, indirect, immediate.
// - Direct destination takes accumulator or immediate byte as second operand.
// - Port destinations read the output latch, not the pins.
// - Opcode 01001rrr picks one of eight working registers.
// - Indirect form reads the pointer, then the memory byte it addresses.
// - Immediate form ORs the byte after the opcode into the accumulator.
// - Opcode 42h plus address byte writes direct OR accumulator back.
// - Direct destination acts as a bit-set mask, immediate or accumulator.
// - Opcode 45h plus address byte ORs that byte into the accumulator.
// - Opcode 44h plus constant byte ORs it into the accumulator.
// - Opcode 43h, then address byte, then constant byte.
// - Opcode 0100011i; lowest bit picks one of two pointer registers.
`include "bor_params.svh"
`timescale 1ns/1ps
`default_nettype none
module bor_exec
	import bor_pkg::*;
(
	input wire logic clock,
	input wire logic rst_b,
	input wire logic start,
	input wire bor_instr_t instr,
	input wire logic [7:0] acc_in,
	input wire logic [1:0] bank_sel,
	input wire logic [7:0] rd_data,
	output logic busy,
	output logic done,
	output logic bad_opcode,
	output var bor_rd_t rd,
	output var bor_wr_t acc_wr,
	output var bor_wr_t mem_wr,
	output logic flag_we
);

	// Opcode classification, used by decode only; the checks compare opcodes directly
	function automatic bor_class_t bor_decode(input logic [7:0] op);
		bor_class_t cl;
		cl = BOR_CL_NONE;
		if (op[7:3] == `BOR_OP_REG_TOP)
			cl = BOR_CL_REG;
		else if (op[7:1] == `BOR_OP_IND_TOP)
			cl = BOR_CL_IND;
		else if (op == `BOR_OP_ACC_DIR)
			cl = BOR_CL_DIR;
		else if (op == `BOR_OP_ACC_IMM)
			cl = BOR_CL_IMM;
		else if (op == `BOR_OP_DIR_ACC)
			cl = BOR_CL_DDA;
		else if (op == `BOR_OP_DIR_IMM)
			cl = BOR_CL_DDI;
		return cl;
	endfunction

	bor_state_t state;
	bor_class_t cls;
	logic [7:0] mask;
	logic [7:0] dest_addr;
	logic ptr_phase;
	bor_class_t start_cls;
	logic taken;

	assign start_cls = bor_decode(instr.opcode);
	assign taken = start && (state == BOR_S_IDLE);

	// Sequencer state
	always_ff @(posedge clock or negedge rst_b)
	begin
		if (!rst_b)
			state <= BOR_S_IDLE;
		else
		begin
			case (state)
				BOR_S_IDLE:
				begin
					if (taken && start_cls == BOR_CL_IMM)
						state <= BOR_S_DONE;
					else if (taken && start_cls != BOR_CL_NONE)
						state <= BOR_S_REQ;
				end
				BOR_S_REQ:
					state <= BOR_S_DATA;
				BOR_S_DATA:
				begin
					if (ptr_phase)
						state <= BOR_S_REQ; // Pointer fetched, now the operand
					else
						state <= BOR_S_DONE;
				end
				default:
					state <= BOR_S_IDLE;
			endcase
		end
	end

	// Captured operands: class, mask byte, destination address
	always_ff @(posedge clock or negedge rst_b)
	begin
		if (!rst_b)
		begin
			cls <= BOR_CL_NONE;
			mask <= `BOR_ZERO_BYTE;
			dest_addr <= `BOR_ZERO_BYTE;
		end
		else if (taken)
		begin
			cls <= start_cls;
			dest_addr <= instr.byte1;
			if (start_cls == BOR_CL_DDI)
				mask <= instr.byte2;
			else
				mask <= acc_in;
		end
	end

	// Pointer phase for the indirect form
	always_ff @(posedge clock or negedge rst_b)
	begin
		if (!rst_b)
			ptr_phase <= 1'b0;
		else if (taken)
			ptr_phase <= (start_cls == BOR_CL_IND);
		else if (state == BOR_S_DATA)
			ptr_phase <= 1'b0;
	end

	// Read port toward internal memory and registers
	always_ff @(posedge clock or negedge rst_b)
	begin
		if (!rst_b)
			rd <= '0;
		else if (taken && start_cls != BOR_CL_NONE && start_cls != BOR_CL_IMM)
		begin
			rd.req <= 1'b1;
			rd.indirect <= 1'b0;
			rd.latch <= (start_cls == BOR_CL_DDA || start_cls == BOR_CL_DDI);
			case (start_cls)
				BOR_CL_REG:
					rd.addr <= {`BOR_ADDR_TOP, bank_sel, instr.opcode[2:0]};
				BOR_CL_IND:
					rd.addr <= {`BOR_ADDR_TOP, bank_sel, `BOR_PTR_GAP, instr.opcode[0]};
				default:
					rd.addr <= instr.byte1;
			endcase
		end
		else if (state == BOR_S_DATA && ptr_phase)
		begin
			rd.req <= 1'b1;
			rd.addr <= rd_data;
			rd.indirect <= 1'b1;
			rd.latch <= 1'b0;
		end
		else
			rd.req <= 1'b0;
	end

	// Accumulator write-back
	always_ff @(posedge clock or negedge rst_b)
	begin
		if (!rst_b)
			acc_wr <= '0;
		else if (taken && start_cls == BOR_CL_IMM)
		begin
			acc_wr.we <= 1'b1;
			acc_wr.data <= acc_in | instr.byte1;
		end
		else if (state == BOR_S_DATA && !ptr_phase && cls != BOR_CL_DDA && cls != BOR_CL_DDI)
		begin
			acc_wr.we <= 1'b1;
			acc_wr.data <= mask | rd_data;
		end
		else
			acc_wr.we <= 1'b0;
	end

	// Direct byte write-back
	always_ff @(posedge clock or negedge rst_b)
	begin
		if (!rst_b)
			mem_wr <= '0;
		else if (state == BOR_S_DATA && !ptr_phase && (cls == BOR_CL_DDA || cls == BOR_CL_DDI))
		begin
			mem_wr.we <= 1'b1;
			mem_wr.addr <= dest_addr;
			mem_wr.data <= mask | rd_data;
		end
		else
			mem_wr.we <= 1'b0;
	end

	// Status: busy, done, bad opcode, flags untouched
	always_ff @(posedge clock or negedge rst_b)
	begin
		if (!rst_b)
		begin
			busy <= 1'b0;
			done <= 1'b0;
			bad_opcode <= 1'b0;
			flag_we <= 1'b0;
		end
		else
		begin
			busy <= taken ? (start_cls != BOR_CL_NONE) : (state != BOR_S_IDLE && state != BOR_S_DONE);
			done <= (taken && start_cls == BOR_CL_IMM) || (state == BOR_S_DATA && !ptr_phase);
			bad_opcode <= taken && start_cls == BOR_CL_NONE;
			flag_we <= 1'b0;
		end
	end

	property p_flags;
		@(posedge clock) disable iff (!rst_b) !flag_we;
	endproperty
	a_flags: assert property (p_flags) else $error("flags written");

	property p_done_with_write;
		@(posedge clock) disable iff (!rst_b) done |-> (acc_wr.we ^ mem_wr.we);
	endproperty
	a_done_with_write: assert property (p_done_with_write) else $error("done without one write");

	property p_imm;
		@(posedge clock) disable iff (!rst_b)
		(start && state == BOR_S_IDLE && instr.opcode == `BOR_OP_ACC_IMM)
		|=> (acc_wr.we && acc_wr.data == ($past(acc_in) | $past(instr.byte1)));
	endproperty
	a_imm: assert property (p_imm) else $error("immediate result wrong");

	property p_reg_addr;
		@(posedge clock) disable iff (!rst_b)
		(taken && instr.opcode[7:3] == `BOR_OP_REG_TOP)
		|=> (rd.req && rd.addr[2:0] == $past(instr.opcode[2:0]) && rd.addr[4:3] == $past(bank_sel));
	endproperty
	a_reg_addr: assert property (p_reg_addr) else $error("register address wrong");

	property p_dir_latch;
		@(posedge clock) disable iff (!rst_b)
		(taken && (instr.opcode == `BOR_OP_DIR_ACC || instr.opcode == `BOR_OP_DIR_IMM))
		|=> (rd.req && rd.latch && rd.addr == $past(instr.byte1));
	endproperty
	a_dir_latch: assert property (p_dir_latch) else $error("direct read not from latch");

	property p_dir_write;
		@(posedge clock) disable iff (!rst_b)
		(taken && instr.opcode == `BOR_OP_DIR_ACC)
		|-> ##3 (mem_wr.we && mem_wr.addr == $past(instr.byte1, 3) && !acc_wr.we);
	endproperty
	a_dir_write: assert property (p_dir_write) else $error("direct write-back wrong");

	property p_acc_dir;
		@(posedge clock) disable iff (!rst_b)
		(taken && instr.opcode == `BOR_OP_ACC_DIR) |-> ##3 (acc_wr.we && done && !mem_wr.we);
	endproperty
	a_acc_dir: assert property (p_acc_dir) else $error("direct form timing wrong");

	property p_ind_two_reads;
		@(posedge clock) disable iff (!rst_b)
		(taken && instr.opcode[7:1] == `BOR_OP_IND_TOP)
		|=> (rd.req && !rd.indirect && rd.addr[0] == $past(instr.opcode[0])) ##2 (rd.req && rd.indirect)
		##2 (acc_wr.we && done);
	endproperty
	a_ind_two_reads: assert property (p_ind_two_reads) else $error("indirect sequence wrong");

	property p_or_result;
		@(posedge clock) disable iff (!rst_b)
		(state == BOR_S_DATA && !ptr_phase)
		|=> ((acc_wr.we ? acc_wr.data : mem_wr.data) == ($past(mask) | $past(rd_data)));
	endproperty
	a_or_result: assert property (p_or_result) else $error("OR result wrong");

	property p_ddi_mask;
		@(posedge clock) disable iff (!rst_b)
		(taken && instr.opcode == `BOR_OP_DIR_IMM) |=> (mask == $past(instr.byte2));
	endproperty
	a_ddi_mask: assert property (p_ddi_mask) else $error("immediate mask wrong");

endmodule // bor_exec
`default_nettype wire

// file: logic/bor_params.svh
// Constants for the byte OR execution unit
`ifndef BOR_PARAMS_SVH
`define BOR_PARAMS_SVH
`define BOR_OP_DIR_ACC 8'h42
`define BOR_OP_DIR_IMM 8'h43
`define BOR_OP_ACC_IMM 8'h44
`define BOR_OP_ACC_DIR 8'h45
`define BOR_OP_IND_TOP 7'h23
`define BOR_OP_REG_TOP 5'h09
`define BOR_ZERO_BYTE 8'h00
`define BOR_PTR_FILL 1'h0
`define BOR_ADDR_TOP 3'h0
`define BOR_PTR_GAP 2'h0
`endif

// file: logic/bor_pkg.sv
// Types for the byte OR execution unit
`default_nettype none
package bor_pkg;
	typedef enum logic [1:0] {
		BOR_S_IDLE = 2'b00,
		BOR_S_REQ = 2'b01,
		BOR_S_DATA = 2'b10,
		BOR_S_DONE = 2'b11
	} bor_state_t;
	typedef enum logic [2:0] {
		BOR_CL_NONE = 3'b000,
		BOR_CL_REG = 3'b001,
		BOR_CL_DIR = 3'b010,
		BOR_CL_IND = 3'b011,
		BOR_CL_IMM = 3'b100,
		BOR_CL_DDA = 3'b101,
		BOR_CL_DDI = 3'b110
	} bor_class_t;
	typedef struct packed {
		logic [7:0] opcode;
		logic [7:0] byte1;
		logic [7:0] byte2;
	} bor_instr_t;
	typedef struct packed {
		logic we;
		logic [7:0] addr;
		logic [7:0] data;
	} bor_wr_t;
	typedef struct packed {
		logic req;
		logic [7:0] addr;
		logic latch;
		logic indirect;
	} bor_rd_t;
endpackage
`default_nettype wire

// file: tb/bor_exec_tb.sv
// Self-checking bench for the byte OR execution unit
`timescale 1ns/1ps
`default_nettype none
module bor_exec_tb
	import bor_pkg::*;
;
	logic clock;
	logic rst_b;
	logic start;
	bor_instr_t instr;
	logic [7:0] acc_in;
	logic [1:0] bank_sel;
	logic [7:0] rd_data = 8'h00;
	logic busy, done, bad_opcode, flag_we;
	bor_rd_t rd;
	bor_wr_t acc_wr;
	bor_wr_t mem_wr;
	int n_mismatch = 0;
	int n_checks = 0;

	bor_exec bor_exec_inst (
		.clock(clock), .rst_b(rst_b), .start(start), .instr(instr), .acc_in(acc_in),
		.bank_sel(bank_sel), .rd_data(rd_data), .busy(busy), .done(done), .bad_opcode(bad_opcode),
		.rd(rd), .acc_wr(acc_wr), .mem_wr(mem_wr), .flag_we(flag_we)
	);

	// Byte store seen by the unit: port latch, indirect RAM, direct byte
	function automatic logic [7:0] rmem(input logic [7:0] a, input logic l, input logic i);
		return l ? (a ^ 8'h3C) : (i ? (a ^ 8'hA5) : (a ^ 8'h5A));
	endfunction

	// Read answer one cycle after a request, scrambled otherwise
	always @(posedge clock)
	begin
		if (rd.req)
			rd_data <= rmem(rd.addr, rd.latch, rd.indirect);
		else
			rd_data <= ~rd_data;
	end

	// Clock, 20 ns period
	initial
	begin
		clock = 1'b0;
		forever #10 clock = ~clock;
	end

	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		n_checks++;
		if (seen !== exp)
		begin
			n_mismatch++;
			$display("unexpected at %0t: seen %0h expected %0h", $time, seen, exp);
		end
	endtask

	task automatic results;
		$display("checks %0d mismatches %0d", n_checks, n_mismatch);
		if (n_mismatch == 0 && n_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	// One instruction; inputs change after start to prove sampling; poke retries start while busy
	task automatic op(input logic [7:0] opc, input logic [7:0] b1, input logic [7:0] b2,
		input logic [7:0] acc, input logic [1:0] bk, input logic [7:0] lat, input logic to_mem,
		input logic [7:0] ea, input logic [7:0] ed, input logic poke);
		logic [7:0] n;
		n = 8'h01;
		@(posedge clock);
		start <= 1'b1;
		instr <= {opc, b1, b2};
		acc_in <= acc;
		bank_sel <= bk;
		@(posedge clock);
		start <= poke;
		instr <= {8'h44, 8'hFF, 8'hFF};
		acc_in <= 8'h00;
		bank_sel <= ~bk;
		#1;
		while (done !== 1'b1 && n < 8'h0A)
		begin
			@(posedge clock);
			start <= 1'b0;
			#1;
			n = n + 8'h01;
		end
		chk(n, lat);
		chk({7'h00, flag_we}, 8'h00);
		chk({6'h00, acc_wr.we, mem_wr.we}, {6'h00, ~to_mem, to_mem});
		chk(to_mem ? mem_wr.data : acc_wr.data, ed);
		chk(to_mem ? mem_wr.addr : acc_wr.addr, ea);
		@(posedge clock);
		#1;
		chk({5'h00, done, busy, acc_wr.we | mem_wr.we}, 8'h00);
	endtask

	// Opcode outside the family: error pulse, no write
	task automatic bad(input logic [7:0] opc);
		@(posedge clock);
		start <= 1'b1;
		instr <= {opc, 8'h12, 8'h34};
		@(posedge clock);
		start <= 1'b0;
		#1;
		chk({6'h00, bad_opcode, acc_wr.we | mem_wr.we}, 8'h02);
		@(posedge clock);
		#1;
		chk({7'h00, bad_opcode}, 8'h00);
	endtask

	// Reset, then every form of the family
	initial
	begin
		rst_b = 1'b0;
		start = 1'b0;
		instr = '0;
		acc_in = 8'h00;
		bank_sel = 2'h0;
		repeat (4) @(posedge clock);
		rst_b <= 1'b1;
		op(8'h44, 8'h14, 8'h00, 8'hC3, 2'h0, 8'h01, 1'b0, 8'h00, 8'hD7, 1'b0);
		for (int r = 0; r < 8; r++)
			op({5'h09, 3'(r)}, 8'h00, 8'h00, 8'hC3, 2'(r), 8'h03, 1'b0, 8'h00,
				8'hC3 | rmem({3'h0, 2'(r), 3'(r)}, 1'b0, 1'b0), 1'b0);
		op(8'h45, 8'h90, 8'h00, 8'h01, 2'h3, 8'h03, 1'b0, 8'h00,
			8'h01 | rmem(8'h90, 1'b0, 1'b0), 1'b1);
		op(8'h42, 8'h90, 8'h00, 8'h22, 2'h0, 8'h03, 1'b1, 8'h90,
			8'h22 | rmem(8'h90, 1'b1, 1'b0), 1'b0);
		op(8'h43, 8'hA0, 8'h32, 8'hFF, 2'h1, 8'h03, 1'b1, 8'hA0,
			8'h32 | rmem(8'hA0, 1'b1, 1'b0), 1'b0);
		for (int i = 0; i < 2; i++)
			op({7'h23, 1'(i)}, 8'h00, 8'h00, 8'h81, 2'h2, 8'h05, 1'b0, 8'h00,
				8'h81 | rmem(rmem({6'h04, 1'b0, 1'(i)}, 1'b0, 1'b0), 1'b0, 1'b1), 1'b0);
		bad(8'h40);
		bad(8'h41);
		bad(8'h50);
		bad(8'h00);
		results();
	end

	// Watchdog against a hung handshake
	initial
	begin
		repeat (3000) @(posedge clock);
		n_mismatch++;
		results();
	end
endmodule // bor_exec_tb
`default_nettype wire
